//--- design/csx_pkg.sv
// Shared constants and types for the cross-space execute and map probe block.
package csx_pkg;

    // Word and bus geometry.
    localparam int WORD_W  = 36;
    localparam int HALF_W  = 18;
    localparam int BUS_AW  = 8;
    localparam int BUS_DW  = 32;
    localparam int PPN_W   = 13;
    localparam int SP_W    = 5;
    localparam int RLD_W   = 5;
    localparam int FAST_AW = 4;
    localparam int UPT_AW  = 9;
    localparam int BLK_W   = 2;
    localparam int AF_W    = 4;
    localparam int CO_W    = 18;

    // Probe opcode, octal 257.
    localparam logic [8:0] PROBE_OPCODE = 9'h0AF;

    // Machine bit n of a word sits at vector index 35-n.
    localparam int IDX_FAIL    = 17;
    localparam int IDX_P       = 16;
    localparam int IDX_W       = 15;
    localparam int IDX_S       = 14;
    localparam int IDX_NOMATCH = 13;

    // Conditions-out word (right half): pointer in bits 18-22, counter in 31-35.
    localparam int CO_SP_LSB  = 13;
    localparam int CO_RLD_LSB = 0;

    // Accumulator field holds bits 9-12; bit 11 is index 1, bit 12 is index 0.
    localparam int AF_WR = 1;
    localparam int AF_RD = 0;

    // Register offsets.
    localparam logic [BUS_AW-1:0] OFS_STATUS = 8'h00;
    localparam logic [BUS_AW-1:0] OFS_MASK   = 8'h04;
    localparam logic [BUS_AW-1:0] OFS_STACK  = 8'h08;
    localparam logic [BUS_AW-1:0] OFS_PROBE  = 8'h0C;
    localparam logic [BUS_AW-1:0] OFS_XCT    = 8'h10;

    // Stack register layout and execute-state readback layout.
    localparam int STK_RLD_LSB = 0;
    localparam int STK_SP_LSB  = 5;
    localparam int XCT_ACT_BIT = 2;

    // Status and mask bits.
    localparam int ST_W       = 4;
    localparam int ST_DONE    = 0;
    localparam int ST_FAIL    = 1;
    localparam int ST_NOMATCH = 2;
    localparam int ST_BYPASS  = 3;
    localparam logic [ST_W-1:0] ST_RESET = 4'h0;

    // Kind of instruction being executed and role of one of its references.
    typedef enum logic [2:0] {CLS_NOMEM, CLS_RD1, CLS_WR1, CLS_TWO,
                              CLS_BLKIN, CLS_BLKOUT, CLS_BYTE} csx_class_t;
    typedef enum logic [1:0] {ROLE_OTHER, ROLE_READ, ROLE_WRITE, ROLE_PTR} csx_role_t;
    typedef enum logic [1:0] {FT_EXEC, FT_SHADOW, FT_BLOCK, FT_STACK} csx_fast_t;

    // Result of one paging lookup.
    typedef struct packed {
        logic             match;
        logic             writeFail;
        logic             p;
        logic             w;
        logic             s;
        logic [PPN_W-1:0] ppn;
    } csx_map_t;

    // One memory reference offered for routing.
    typedef struct packed {
        csx_class_t         cls;
        csx_role_t          role;
        logic               fast;
        logic [FAST_AW-1:0] addr;
        logic               concealed;
    } csx_ref_t;

    // Routing decision for one reference.
    typedef struct packed {
        logic              valid;
        logic              toUser;
        csx_fast_t         fast;
        logic [BLK_W-1:0]  block;
        logic [UPT_AW-1:0] uptAddr;
        logic              pageFail;
    } csx_route_t;

endpackage

//--- design/csx_map_probe.sv
// Address translation probe and executive cross-space operand routing.
//
// Operation
// - Probe writes map entry to accumulator right half.
// - Probe never faults; bit 18 flags write failure.
// - Probe sets bit 22 when no match.
// - Both flags set means right half invalid.
// - Conditions ops and probe inspect associative entries.
// - Only operand references may leave executive space.
// - Field bits 11,12 select; ignored in user mode.
// - Bit 12 reads/RMW, bit 11 writes.
// - User-IO set: core and fast; clear: fast only.
// - User-IO set: shadow if block 0, else block.
// - User-IO clear: fast refs go to stack group.
// - Stack pointer forms top of 9-bit table address.
// - Bypass disabled makes supervisor user-space concealed access page fail.
// - Nested execute-indirect cancels the space effect.
// - Read bit governs read and same-location write-back.
// - Write-only instructions use the write bit.
// - Two-location: read bit source, write bit destination.
// - Block in write bit, out read bit.
// - Byte pointers executive; select bits hit final reference.
//
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

module csx_map_probe (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic [csx_pkg::BUS_AW-1:0]   busAddr,
    input  wire logic [csx_pkg::BUS_DW-1:0]   busWrData,
    input  wire logic                         busWr,
    input  wire logic                         busRd,
    output logic      [csx_pkg::BUS_DW-1:0]   busRdData,
    output logic                              irq,
    input  wire logic                         probeReq,
    input  wire logic [8:0]                   probeOpcode,
    input  wire csx_pkg::csx_map_t            probeMap,
    output logic                              probeUserSpace,
    output logic      [csx_pkg::WORD_W-1:0]   probeResult,
    output logic                              probeDone,
    output logic                              probeValid,
    input  wire logic                         condOutReq,
    input  wire logic [csx_pkg::CO_W-1:0]     condOutData,
    output logic      [csx_pkg::RLD_W-1:0]    amSelect,
    output logic      [csx_pkg::SP_W-1:0]     stackPtr,
    input  wire logic                         xctIssue,
    input  wire logic [csx_pkg::AF_W-1:0]     xctAcField,
    input  wire logic                         userMode,
    input  wire logic                         instrDone,
    input  wire logic                         userIo,
    input  wire logic [csx_pkg::BLK_W-1:0]    userBlock,
    input  wire logic                         supervisorMode,
    input  wire logic                         disableBypass,
    input  wire logic                         refValid,
    input  wire csx_pkg::csx_ref_t            refIn,
    output csx_pkg::csx_route_t               route
);

    // Decide whether one reference is steered by the select bits.
    // Pointer and non-operand roles never are, except block pointers.
    function automatic logic refSelected(input csx_pkg::csx_class_t c,
                                         input csx_pkg::csx_role_t  r,
                                         input logic [1:0]          s);
        logic rd;
        logic wr;
        rd = s[csx_pkg::AF_RD];
        wr = s[csx_pkg::AF_WR];
        refSelected = 1'b0;
        unique case (c)
            // Read bit also covers the write-back to the same word.
            csx_pkg::CLS_RD1: begin
                refSelected = rd & (r == csx_pkg::ROLE_READ | r == csx_pkg::ROLE_WRITE);
            end
            // Write-only instructions, the probe among them.
            csx_pkg::CLS_WR1: begin
                refSelected = wr & (r == csx_pkg::ROLE_WRITE);
            end
            // Source and destination take separate bits; byte pointers stay put.
            csx_pkg::CLS_TWO, csx_pkg::CLS_BYTE: begin
                if (r == csx_pkg::ROLE_READ) begin
                    refSelected = rd;
                end else if (r == csx_pkg::ROLE_WRITE) begin
                    refSelected = wr;
                end else begin
                    refSelected = 1'b0;
                end
            end
            // The block pointer follows its data transfer.
            csx_pkg::CLS_BLKIN: begin
                refSelected = wr & (r != csx_pkg::ROLE_OTHER);
            end
            csx_pkg::CLS_BLKOUT: begin
                refSelected = rd & (r != csx_pkg::ROLE_OTHER);
            end
            // No memory operands, or an unused code.
            default: begin
                refSelected = 1'b0;
            end
        endcase
    endfunction

    // Execute-indirect select state.
    logic [1:0] xctSel_q;    // Effective bit 11/12 selection for the target.
    logic [1:0] xctSel_d;
    logic       xctAct_q;    // An execute-indirect, issued in either mode, is in progress.
    logic       xctAct_d;

    // Stack pointer and reload counter.
    logic [csx_pkg::SP_W-1:0]  sp_q;
    logic [csx_pkg::SP_W-1:0]  sp_d;
    logic [csx_pkg::RLD_W-1:0] rld_q;
    logic [csx_pkg::RLD_W-1:0] rld_d;

    // Probe result state.
    logic [csx_pkg::WORD_W-1:0] probeWord_q;
    logic [csx_pkg::WORD_W-1:0] probeWord_d;
    logic                       probeDone_q;
    logic                       probeDone_d;
    logic                       probeValid_q;
    logic                       probeValid_d;

    // Routing state.
    csx_pkg::csx_route_t route_q;
    csx_pkg::csx_route_t route_d;

    // Register file state.
    logic [csx_pkg::ST_W-1:0]   status_q;
    logic [csx_pkg::ST_W-1:0]   status_d;
    logic [csx_pkg::ST_W-1:0]   mask_q;
    logic [csx_pkg::ST_W-1:0]   mask_d;
    logic [csx_pkg::BUS_DW-1:0] rdData_q;
    logic [csx_pkg::BUS_DW-1:0] rdData_d;

    // Event strobes into the status register.
    logic probeHit;          // A probe opcode was accepted this cycle.
    logic refSel;            // The offered reference is steered by the bits.
    logic refUser;           // The offered reference goes to user space.

    assign probeHit = probeReq & (probeOpcode == csx_pkg::PROBE_OPCODE);

    // Latch the field bits when an execute-indirect is issued.
    // A second issue while one is active is the inner of a pair: it clears
    // the selection so the third instruction runs entirely in executive space.
    always_comb begin
        xctSel_d = xctSel_q;
        xctAct_d = xctAct_q;
        if (xctIssue) begin
            if (xctAct_q) begin
                xctSel_d = 2'h0;
            end else if (userMode) begin
                xctSel_d = 2'h0;
            end else begin
                xctSel_d = {xctAcField[csx_pkg::AF_WR], xctAcField[csx_pkg::AF_RD]};
            end
            xctAct_d = 1'b1;
        end else if (instrDone) begin
            // End of the target instruction drops every space effect.
            xctSel_d = 2'h0;
            xctAct_d = 1'b0;
        end
    end

    // Register the execute-indirect state.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            xctSel_q <= 2'h0;
            xctAct_q <= 1'b0;
        end else begin
            xctSel_q <= xctSel_d;
            xctAct_q <= xctAct_d;
        end
    end

    // Stack pointer and counter load from the conditions-out operation.
    // The port wins over a bus write in the same cycle, since the processor
    // operation is the architected path and software writes are diagnostic.
    always_comb begin
        sp_d  = sp_q;
        rld_d = rld_q;
        if (condOutReq) begin
            sp_d  = condOutData[csx_pkg::CO_SP_LSB +: csx_pkg::SP_W];
            rld_d = condOutData[csx_pkg::CO_RLD_LSB +: csx_pkg::RLD_W];
        end else if (busWr && busAddr == csx_pkg::OFS_STACK) begin
            sp_d  = busWrData[csx_pkg::STK_SP_LSB +: csx_pkg::SP_W];
            rld_d = busWrData[csx_pkg::STK_RLD_LSB +: csx_pkg::RLD_W];
        end
    end

    // Register the stack pointer and counter.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q  <= '0;
            rld_q <= '0;
        end else begin
            sp_q  <= sp_d;
            rld_q <= rld_d;
        end
    end

    // The counter selects the associative entry that the conditions-in
    // operation reads; a probe of that page then returns its physical part.
    assign amSelect = rld_q;
    assign stackPtr = sp_q;

    // The probe is a write-only reference, so under an executive
    // execute-indirect with user-IO set the write bit picks the space it looks up.
    assign probeUserSpace = refSelected(csx_pkg::CLS_WR1, csx_pkg::ROLE_WRITE, xctSel_q)
                            & userIo;

    // Build the probe word.  The lookup failure is only reported, never
    // raised, so no page-fail path leaves this logic.
    always_comb begin
        probeWord_d  = probeWord_q;
        probeValid_d = probeValid_q;
        probeDone_d  = 1'b0;
        if (probeHit) begin
            probeWord_d                        = '0;
            probeWord_d[csx_pkg::IDX_FAIL]     = probeMap.writeFail;
            probeWord_d[csx_pkg::IDX_P]        = probeMap.p;
            probeWord_d[csx_pkg::IDX_W]        = probeMap.w;
            probeWord_d[csx_pkg::IDX_S]        = probeMap.s;
            probeWord_d[csx_pkg::IDX_NOMATCH]  = ~probeMap.match;
            probeWord_d[csx_pkg::PPN_W-1:0]    = probeMap.ppn;
            // A failure with a match still returns good map data.
            probeValid_d = ~(probeMap.writeFail & ~probeMap.match);
            probeDone_d  = 1'b1;
        end
    end

    // Register the probe outputs.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            probeWord_q  <= '0;
            probeDone_q  <= 1'b0;
            probeValid_q <= 1'b0;
        end else begin
            probeWord_q  <= probeWord_d;
            probeDone_q  <= probeDone_d;
            probeValid_q <= probeValid_d;
        end
    end

    assign probeResult = probeWord_q;
    assign probeDone   = probeDone_q;
    assign probeValid  = probeValid_q;

    // Fetches, address calculation and accumulator references carry the
    // other role and so never qualify.  Core references qualify only with
    // user-IO set.
    assign refSel  = refValid & refSelected(refIn.cls, refIn.role, xctSel_q);
    assign refUser = refSel & (refIn.fast | userIo);

    // Route the offered reference, one cycle later.
    always_comb begin
        route_d         = '0;
        route_d.fast    = csx_pkg::FT_EXEC;
        route_d.valid   = refValid;
        route_d.toUser  = refUser;
        route_d.block   = userBlock;
        route_d.uptAddr = {sp_q, refIn.addr};
        if (refUser && refIn.fast) begin
            if (!userIo) begin
                route_d.fast = csx_pkg::FT_STACK;
            end else if (userBlock == '0) begin
                route_d.fast = csx_pkg::FT_SHADOW;
            end else begin
                route_d.fast = csx_pkg::FT_BLOCK;
            end
        end
        // The bypass lets supervisor code into the concealed area unless
        // the flag is set in the PC word.
        route_d.pageFail = refUser & refIn.concealed & supervisorMode
                           & disableBypass;
    end

    // Register the routing decision.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            route_q <= '0;
        end else begin
            route_q <= route_d;
        end
    end

    assign route = route_q;

    // Status bits are sticky; a write of one clears, an event in the same
    // cycle wins so nothing is lost.
    always_comb begin
        status_d = status_q;
        mask_d   = mask_q;
        if (busWr && busAddr == csx_pkg::OFS_STATUS) begin
            status_d = status_q & ~busWrData[csx_pkg::ST_W-1:0];
        end
        if (busWr && busAddr == csx_pkg::OFS_MASK) begin
            mask_d = busWrData[csx_pkg::ST_W-1:0];
        end
        if (probeHit) begin
            status_d[csx_pkg::ST_DONE] = 1'b1;
        end
        if (probeHit && probeMap.writeFail) begin
            status_d[csx_pkg::ST_FAIL] = 1'b1;
        end
        if (probeHit && !probeMap.match) begin
            status_d[csx_pkg::ST_NOMATCH] = 1'b1;
        end
        if (route_d.pageFail) begin
            status_d[csx_pkg::ST_BYPASS] = 1'b1;
        end
    end

    // Read data for the cycle after the strobe; unmapped offsets read zero.
    always_comb begin
        rdData_d = '0;
        if (busRd) begin
            unique case (busAddr)
                csx_pkg::OFS_STATUS: rdData_d[csx_pkg::ST_W-1:0] = status_q;
                csx_pkg::OFS_MASK:   rdData_d[csx_pkg::ST_W-1:0] = mask_q;
                csx_pkg::OFS_STACK: begin
                    rdData_d[csx_pkg::STK_SP_LSB +: csx_pkg::SP_W]   = sp_q;
                    rdData_d[csx_pkg::STK_RLD_LSB +: csx_pkg::RLD_W] = rld_q;
                end
                csx_pkg::OFS_PROBE: begin
                    rdData_d[csx_pkg::HALF_W-1:0] = probeWord_q[csx_pkg::HALF_W-1:0];
                end
                csx_pkg::OFS_XCT: begin
                    rdData_d[1:0]                  = xctSel_q;
                    rdData_d[csx_pkg::XCT_ACT_BIT] = xctAct_q;
                end
                default: rdData_d = '0;
            endcase
        end
    end

    // Register the register file.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= csx_pkg::ST_RESET;
            mask_q   <= csx_pkg::ST_RESET;
            rdData_q <= '0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            rdData_q <= rdData_d;
        end
    end

    assign busRdData = rdData_q;

    // Level interrupt while any unmasked status bit stands.
    assign irq = |(status_q & mask_q);

endmodule // csx_map_probe

`default_nettype wire

//--- test/csx_map_probe_asserts.sv
// Port-level checker for the map probe and cross-space routing block.
`timescale 1ns/10ps
`default_nettype none
module csx_map_probe_asserts (
    input wire logic                       sys_clk,
    input wire logic                       rst_n,
    input wire logic                       probeReq,
    input wire logic [8:0]                 probeOpcode,
    input wire csx_pkg::csx_map_t          probeMap,
    input wire logic [csx_pkg::WORD_W-1:0] probeResult,
    input wire logic                       probeDone,
    input wire logic                       probeValid,
    input wire logic [csx_pkg::SP_W-1:0]   stackPtr,
    input wire logic                       userIo,
    input wire logic [csx_pkg::BLK_W-1:0]  userBlock,
    input wire logic                       disableBypass,
    input wire logic                       refValid,
    input wire csx_pkg::csx_ref_t          refIn,
    input wire csx_pkg::csx_route_t        route
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    // A probe only counts when it carries the probe opcode.
    wire logic take = probeReq && (probeOpcode == csx_pkg::PROBE_OPCODE);

    a_probe_done: assert property (take |=> probeDone)
        else $error("probe not answered");
    a_probe_refuse: assert property (!take |=> !probeDone)
        else $error("probe done without a request");
    a_left_clear: assert property (probeDone |-> probeResult[35:18] == 18'h00000)
        else $error("probe left half not clear");
    a_map_copy: assert property (take |=> probeResult[16:0] == {$past(probeMap.p),
        $past(probeMap.w), $past(probeMap.s), !$past(probeMap.match), $past(probeMap.ppn)})
        else $error("probe map data wrong");
    a_fail_flag: assert property (take |=> probeResult[17] == $past(probeMap.writeFail))
        else $error("probe fail flag wrong");
    a_valid_flag: assert property (probeDone |-> probeValid ==
        !(probeResult[17] && probeResult[13]))
        else $error("probe valid flag wrong");
    a_route_pulse: assert property (route.valid == $past(refValid))
        else $error("route valid not one cycle after request");
    a_core_exec: assert property (refValid && !userIo && !refIn.fast |=> !route.toUser)
        else $error("core reference left executive space");
    a_shadow_pick: assert property (refValid && userIo && refIn.fast &&
        userBlock == 2'h0 |=> route.toUser == (route.fast == csx_pkg::FT_SHADOW))
        else $error("shadow area not chosen");
    a_stack_pick: assert property (refValid && !userIo |=>
        route.fast != csx_pkg::FT_SHADOW && route.fast != csx_pkg::FT_BLOCK)
        else $error("stacked group not chosen");
    a_stack_addr: assert property (refValid |=>
        route.uptAddr == {$past(stackPtr), $past(refIn.addr)})
        else $error("table address wrong");
    a_bypass_ok: assert property (refValid && !disableBypass |=> !route.pageFail)
        else $error("page fail with bypass enabled");

    // Main scenarios that the bench is expected to reach.
    c_probe_bad: cover property (take && probeMap.writeFail && !probeMap.match);
    c_stack_ref: cover property (refValid && !userIo && refIn.fast);
    c_conceal: cover property (refValid && refIn.concealed && disableBypass);
endmodule // csx_map_probe_asserts

bind csx_map_probe csx_map_probe_asserts chk_u (.sys_clk, .rst_n, .probeReq, .probeOpcode,
    .probeMap, .probeResult, .probeDone, .probeValid, .stackPtr, .userIo, .userBlock,
    .disableBypass, .refValid, .refIn, .route);
`default_nettype wire

//--- test/tb.sv
// Self-checking bench for the map probe and cross-space routing block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic                  sys_clk = 1'b0;        // 50 MHz clock.
    logic                  rst_n = 1'b0;          // Asynchronous reset, active low.
    logic [7:0]            busAddr = 8'h00;
    logic [31:0]           busWrData = 32'h0;
    logic                  busWr = 1'b0;
    logic                  busRd = 1'b0;
    logic [31:0]           busRdData;
    logic                  irq;
    logic                  probeReq = 1'b0;
    logic [8:0]            probeOpcode = 9'h000;
    csx_pkg::csx_map_t     probeMap = '0;
    logic                  probeUserSpace;
    logic [35:0]           probeResult;
    logic                  probeDone;
    logic                  probeValid;
    logic                  condOutReq = 1'b0;
    logic [17:0]           condOutData = 18'h0;
    logic [4:0]            amSelect;
    logic [4:0]            stackPtr;
    logic                  xctIssue = 1'b0;
    logic [3:0]            xctAcField = 4'h0;
    logic                  userMode = 1'b0;
    logic                  instrDone = 1'b0;
    logic                  userIo = 1'b1;
    logic [1:0]            userBlock = 2'h0;
    logic                  supervisorMode = 1'b0;
    logic                  disableBypass = 1'b0;
    logic                  refValid = 1'b0;
    csx_pkg::csx_ref_t     refIn = '0;
    csx_pkg::csx_route_t   route;
    int                    errors = 0;            // Mismatches seen.
    int                    nChecks = 0;           // Comparisons made.
    logic                  concealRef = 1'b0;     // Concealed flag for the next reference.
    // Reference kinds: class, role and governing bit (0 read, 1 write, 2 none).
    logic [2:0] tc [10] = '{3'h1, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h5, 3'h6, 3'h6, 3'h0};
    logic [1:0] tr [10] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2, 2'h3, 2'h3, 2'h0, 2'h2, 2'h1};
    logic [1:0] tg [10] = '{2'h0, 2'h0, 2'h1, 2'h0, 2'h1, 2'h1, 2'h0, 2'h2, 2'h1, 2'h2};

    csx_map_probe dut_u (.sys_clk, .rst_n, .busAddr, .busWrData, .busWr, .busRd, .busRdData,
        .irq, .probeReq, .probeOpcode, .probeMap, .probeUserSpace, .probeResult, .probeDone,
        .probeValid, .condOutReq, .condOutData, .amSelect, .stackPtr, .xctIssue, .xctAcField,
        .userMode, .instrDone, .userIo, .userBlock, .supervisorMode, .disableBypass,
        .refValid, .refIn, .route);

    // Clock toggles every half period.
    always #10 sys_clk = ~sys_clk;

    // Compare one value; four-state equality so an unknown never matches.
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        nChecks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    // Each access leaves one idle cycle so no strobe is driven twice in a step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        busAddr <= a;
        busWrData <= d;
        busWr <= 1'b1;
        @(posedge sys_clk);
        busWr <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Read data stands only in the cycle after the strobe, so sample it there.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        busAddr <= a;
        busRd <= 1'b1;
        @(posedge sys_clk);
        busRd <= 1'b0;
        #1 d = busRdData;
        @(posedge sys_clk);
    endtask

    task automatic probe(input logic [8:0] op, input csx_pkg::csx_map_t m);
        probeOpcode <= op;
        probeMap <= m;
        probeReq <= 1'b1;
        @(posedge sys_clk);
        probeReq <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic execute_indirect_instr(input logic [3:0] f, input logic um);
        xctAcField <= f;
        userMode <= um;
        xctIssue <= 1'b1;
        @(posedge sys_clk);
        xctIssue <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic done;
        instrDone <= 1'b1;
        @(posedge sys_clk);
        instrDone <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Offer one reference and compare the whole routing answer a cycle later.
    task automatic doref(input logic [2:0] c, input logic [1:0] r, input logic f,
                         input logic u, input logic [1:0] ft, input logic pf);
        refIn <= {c, r, f, 4'hA, concealRef};
        refValid <= 1'b1;
        @(posedge sys_clk);
        refValid <= 1'b0;
        #1 chk({route.valid, route.toUser, route.fast, route.pageFail, route.block, route.uptAddr},
               {1'b1, u, ft, pf, userBlock, 5'h15, 4'hA});
        @(posedge sys_clk);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang is cut short after far more cycles than the tests need.
    initial begin
        repeat (5000) @(posedge sys_clk);
        errors++;
        final_report;
    end

    initial begin
        logic [31:0] d;
        logic [3:0]  s;
        repeat (10) @(posedge sys_clk);
        rst_n <= 1'b1;
        rd(8'h00, d); chk(d, 32'h0);
        rd(8'h08, d); chk(d, 32'h0);
        wr(8'h20, 32'hFFFF);
        rd(8'h20, d); chk(d, 32'h0);
        condOutData <= 18'h2A003;
        condOutReq <= 1'b1;
        @(posedge sys_clk);
        condOutReq <= 1'b0;
        @(posedge sys_clk);
        chk({stackPtr, amSelect}, {5'h15, 5'h03});
        rd(8'h08, d); chk(d, 32'h2A3);
        $display("test registers finished");
        // All four flag combinations; valid data unless failed without a match.
        for (int i = 0; i < 4; i++) begin
            probe(9'h0AF, {i[0], i[1], 3'h5, 13'h1ABC});
            chk({probeValid, probeResult}, {!(i[1] && !i[0]), 18'h0, i[1], 3'h5, !i[0],
                13'h1ABC});
        end
        probe(9'h0AE, {1'b1, 1'b1, 3'h0, 13'h0});
        chk(probeResult[17:13], 5'h1A);
        rd(8'h00, d); chk(d, 32'h7);
        wr(8'h04, 32'h1);
        chk(irq, 1'b1);
        wr(8'h00, 32'h1);
        chk(irq, 1'b0);
        rd(8'h00, d); chk(d, 32'h6);
        wr(8'h00, 32'hF);
        $display("test probe finished");
        // Every select code against every reference kind, core space.
        for (int k = 0; k < 4; k++) begin
            s = k[3:0];
            execute_indirect_instr(s, 1'b0);
            rd(8'h10, d); chk(d, {29'h0, 1'b1, s[1:0]});
            chk(probeUserSpace, s[1]);
            for (int j = 0; j < 10; j++) begin
                doref(tc[j], tr[j], 1'b0, (tg[j] == 2'h2) ? 1'b0 : s[tg[j]], 2'h0, 1'b0);
            end
            done;
        end
        $display("test selection finished");
        execute_indirect_instr(4'h3, 1'b0);
        doref(3'h1, 2'h1, 1'b1, 1'b1, csx_pkg::FT_SHADOW, 1'b0);
        userBlock <= 2'h2;
        doref(3'h1, 2'h1, 1'b1, 1'b1, csx_pkg::FT_BLOCK, 1'b0);
        userIo <= 1'b0;
        doref(3'h2, 2'h2, 1'b1, 1'b1, csx_pkg::FT_STACK, 1'b0);
        doref(3'h2, 2'h2, 1'b0, 1'b0, 2'h0, 1'b0);
        userIo <= 1'b1;
        supervisorMode <= 1'b1;
        disableBypass <= 1'b1;
        concealRef = 1'b1;
        doref(3'h1, 2'h1, 1'b0, 1'b1, 2'h0, 1'b1);
        disableBypass <= 1'b0;
        doref(3'h1, 2'h1, 1'b0, 1'b1, 2'h0, 1'b0);
        rd(8'h00, d); chk(d, 32'h8);
        concealRef = 1'b0;
        execute_indirect_instr(4'h3, 1'b0);
        rd(8'h10, d); chk(d, 32'h4);
        doref(3'h1, 2'h1, 1'b0, 1'b0, 2'h0, 1'b0);
        done;
        rd(8'h10, d); chk(d, 32'h0);
        execute_indirect_instr(4'h3, 1'b1);
        doref(3'h2, 2'h2, 1'b0, 1'b0, 2'h0, 1'b0);
        done;
        $display("test routing finished");
        final_report;
    end
endmodule // tb
`default_nettype wire
